/* File: src/btg_top.sv */
`timescale 1ns/1ps
//
// Function
// - Enable drives tone, else inactive level
// - Build-time polarity sets resting level
// - Eight tones divided from low-speed clock
// - Eight duty levels per tone group
// - Duty is active-level time over period
// - Envelope overrides level_select duty
// - Envelope starts level 1, decays toward 8
// - Envelope holds at level 8
// - env_restart returns envelope to level 1
// - Step time 62.5 or 125 msec
// - First envelope step may be 4 msec off
// - One-shot lasts 125 or 31.25 msec
// - One-shot starts and ends on 256 Hz tick
// - shot_trigger reads busy status
// - shot_stop ends one-shot on tick
// - Retrigger restarts full one-shot duration
// - One-shot uses level_select, no envelope
// - Triggers ignored while buzzer_enable set
// - shot_stop write-only, reads zero
// - level_select register after tone register
// - env_restart ignored unless enveloped tone
// - shot_stop ignored unless one-shot active
//
module btg_top
  import btg_pkg::*;
#(
  parameter bit POSITIVE_POL = 1'b1  // 1: rests low, 0: rests high
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_IN,
  input  wire logic        LOW_SPEED_OSC_IN,
  input  wire logic [15:0] ADDR_IN,
  input  wire logic [3:0]  WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [3:0]  RDATA_OUT,
  output logic             BUZZER_OUT
);

  // Register state
  logic       buzzer_enable_q;    // Normal tone output on
  logic       env_on_q;           // Envelope added to normal tone
  logic       env_step_time_q;    // 0: 62.5 msec steps, 1: 125 msec
  logic       pulse_len_select_q; // 0: 31.25 msec shot, 1: 125 msec
  logic [2:0] tone_select_q;      // Tone frequency code
  logic [2:0] level_select_q;     // Fixed duty level code

  // Oscillator edges and slow ticks
  logic       osc_rise;           // Accepted rising edge of low-speed clock
  logic       osc_fall;           // Accepted falling edge
  logic [6:0] pre_q;              // Divider to the 256 Hz tick
  logic       tick256;            // One-cycle 256 Hz enable

  // Tone generator
  logic       tone_tick;          // Tone counter advance
  logic [4:0] tone_cnt_q;         // Position inside the tone period
  logic [4:0] period_last;        // Last count of the period
  logic       gate_q;             // Tone gate, changes on period boundary
  logic       tone_req;           // Some source asks for tone
  logic [2:0] duty_level;         // Level in use this cycle
  logic [4:0] duty_high;          // Active counts in the period
  logic       active_d;           // Active phase of the waveform

  // Envelope
  logic       env_run;            // Envelope in effect
  logic [2:0] env_level_q;        // Current envelope level
  logic [5:0] env_cnt_q;          // 256 Hz ticks inside a step
  logic [5:0] env_step_last;      // Last tick count of a step

  // One-shot
  btg_shot_e  shot_state_q;       // Sequencer state
  logic [5:0] shot_cnt_q;         // 256 Hz ticks spent running
  logic [5:0] shot_last;          // Last tick count of the shot
  logic       shot_stop_q;        // Stop request waiting for a tick
  logic       shot_on_q;          // One-shot tone in progress
  logic       shot_busy;          // Status seen by the CPU

  // Write decode
  logic       wr_env;             // Write to buzzer_envelope_control
  logic       wr_shot;            // Write to oneshot_control
  logic       shot_trig_wr;       // Accepted trigger write
  logic       shot_stop_wr;       // Accepted stop write
  logic       env_restart_wr;     // Accepted envelope restart write
  logic [3:0] rdata_d;            // Read mux

  // Oscillator edge recovery; it is not related to CLK_SYS_IN
  btg_osc_sync u_osc_sync (
    .clk_in   (CLK_SYS_IN),
    .rst_in   (RST_IN),
    .osc_in   (LOW_SPEED_OSC_IN),
    .rise_out (osc_rise),
    .fall_out (osc_fall)
  );

  // Write strobes for the control nibbles
  // Reads have no side effects, so only writes need decoding here
  assign wr_env  = WR_IN && (ADDR_IN == BTG_ADDR_ENV_CTRL);
  assign wr_shot = WR_IN && (ADDR_IN == BTG_ADDR_SHOT_CTRL);
  // Triggers are dropped while normal tone is on
  assign shot_trig_wr   = wr_shot && WDATA_IN[BTG_BIT_SHOT_TRIG] && !buzzer_enable_q;
  // Stop only counts during a one-shot; writing 0 does nothing
  assign shot_stop_wr   = wr_shot && WDATA_IN[BTG_BIT_SHOT_STOP] && shot_busy;
  // Restart only counts while an enveloped tone is playing
  assign env_restart_wr = wr_env && WDATA_IN[BTG_BIT_ENV_RESTART] && env_run;

  // Plain read/write control bits
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      buzzer_enable_q    <= 1'b0;
      env_on_q           <= 1'b0;
      env_step_time_q    <= 1'b0;
      pulse_len_select_q <= 1'b0;
      tone_select_q      <= BTG_RST_SEL;
      level_select_q     <= BTG_RST_SEL;
    end else if (WR_IN) begin
      unique case (ADDR_IN)
        BTG_ADDR_ENV_CTRL: begin
          buzzer_enable_q <= WDATA_IN[BTG_BIT_BZ_EN];
          env_on_q        <= WDATA_IN[BTG_BIT_ENV_ON];
          env_step_time_q <= WDATA_IN[BTG_BIT_ENV_STEP];
        end
        BTG_ADDR_SHOT_CTRL: begin
          pulse_len_select_q <= WDATA_IN[BTG_BIT_PULSE_LEN];
        end
        BTG_ADDR_TONE_SEL: begin
          tone_select_q <= WDATA_IN[2:0];
        end
        BTG_ADDR_LEVEL_SEL: begin
          level_select_q <= WDATA_IN[2:0];
        end
        default: begin
          // Other addresses belong to other blocks
        end
      endcase
    end
  end

  // Read mux; restart and stop strobes and unused bits read as zero
  always_comb begin
    rdata_d = BTG_RST_NIBBLE;
    unique case (ADDR_IN)
      BTG_ADDR_ENV_CTRL: begin
        rdata_d[BTG_BIT_BZ_EN]    = buzzer_enable_q;
        rdata_d[BTG_BIT_ENV_ON]   = env_on_q;
        rdata_d[BTG_BIT_ENV_STEP] = env_step_time_q; // Restart bit stays 0
      end
      BTG_ADDR_SHOT_CTRL: begin
        rdata_d[BTG_BIT_PULSE_LEN] = pulse_len_select_q;
        rdata_d[BTG_BIT_SHOT_TRIG] = shot_busy;       // Stop bit stays 0
      end
      BTG_ADDR_TONE_SEL: begin
        rdata_d[2:0] = tone_select_q;
      end
      BTG_ADDR_LEVEL_SEL: begin
        rdata_d[2:0] = level_select_q;
      end
      default: begin
        rdata_d = BTG_RST_NIBBLE;
      end
    endcase
  end

  // Read data register, loaded on a read strobe and held otherwise
  // Holding the value lets a slow CPU sample it any time after the strobe
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= BTG_RST_NIBBLE;
    end else if (RD_IN) begin
      RDATA_OUT <= rdata_d;
    end
  end

  // Divider from the oscillator down to the 256 Hz tick
  // It runs free from reset, so one-shot and envelope timing share one phase
  assign tick256 = osc_rise && (pre_q == BTG_PRE_LAST);
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pre_q <= 7'h00;
    end else if (osc_rise) begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // Tone counter: the fast half of the codes counts both oscillator edges,
  // the slow half only rising ones, so both halves share one duty table
  assign tone_tick   = tone_select_q[2] ? osc_rise : (osc_rise || osc_fall);
  assign period_last = BTG_PERIOD_BASE + 5'(BTG_PERIOD_STEP * tone_select_q[1:0]) - 5'h01;

  // Period counter and synchronous gate; a mid-period code change that
  // leaves the count past the new end simply wraps at the next tick
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tone_cnt_q <= 5'h00;
      gate_q     <= 1'b0;
    end else if (tone_tick) begin
      if (tone_cnt_q >= period_last) begin
        tone_cnt_q <= 5'h00;
        gate_q     <= tone_req;
      end else begin
        tone_cnt_q <= tone_cnt_q + 5'h01;
      end
    end
  end

  // Duty source: envelope on normal tone only, never on the one-shot
  assign tone_req   = buzzer_enable_q || shot_on_q;
  assign env_run    = env_on_q && buzzer_enable_q;
  assign duty_level = env_run ? env_level_q : level_select_q;
  assign duty_high  = (tone_select_q[1] ? BTG_DUTY_MAX_LONG : BTG_DUTY_MAX_SHORT)
                      - {2'b00, duty_level};
  assign active_d   = gate_q && (tone_cnt_q < duty_high);

  // Output pin register with the fixed polarity
  // Registering the pin costs one cycle of lag but removes decode glitches
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      BUZZER_OUT <= !POSITIVE_POL;
    end else begin
      BUZZER_OUT <= POSITIVE_POL ? active_d : !active_d;
    end
  end

  // Envelope stepper; the step timer restarts with the tone, so the first
  // step is early by at most one 256 Hz tick (under 4 msec)
  // The level saturates at the minimum rather than wrapping to the loudest
  assign env_step_last = (env_step_time_q ? BTG_ENV_STEP_LONG_TK : BTG_ENV_STEP_SHORT_TK)
                         - 6'h01;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      env_level_q <= BTG_RST_SEL;
      env_cnt_q   <= 6'h00;
    end else if (!env_run || env_restart_wr) begin
      env_level_q <= BTG_RST_SEL;
      env_cnt_q   <= 6'h00;
    end else if (tick256) begin
      if (env_cnt_q >= env_step_last) begin
        env_cnt_q <= 6'h00;
        if (env_level_q != BTG_LEVEL_MIN) begin
          env_level_q <= env_level_q + 3'h1;
        end
      end else begin
        env_cnt_q <= env_cnt_q + 6'h01; // Holding at level 8 just counts
      end
    end
  end

  // Pending stop: set by an accepted write, consumed at the next tick
  // A stop that lands on a tick cycle is honoured at the following tick
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      shot_stop_q <= 1'b0;
    end else if (shot_stop_wr) begin
      shot_stop_q <= 1'b1;
    end else if (tick256 || shot_state_q == BTG_SHOT_IDLE) begin
      shot_stop_q <= 1'b0;
    end
  end

  // Busy covers the wait for the first tick as well as the run
  assign shot_busy = (shot_state_q != BTG_SHOT_IDLE);
  assign shot_last = (pulse_len_select_q ? BTG_SHOT_LONG_TK : BTG_SHOT_SHORT_TK)
                     - 6'h01;

  // One-shot sequencer; a trigger always waits for the next tick, and a
  // retrigger keeps the tone sounding while it waits
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      shot_state_q <= BTG_SHOT_IDLE;
      shot_cnt_q   <= 6'h00;
      shot_on_q    <= 1'b0;
    end else if (shot_trig_wr) begin
      shot_state_q <= BTG_SHOT_WAIT;
    end else if (tick256) begin
      unique case (shot_state_q)
        BTG_SHOT_IDLE: begin
          shot_on_q <= 1'b0;
        end
        BTG_SHOT_WAIT: begin
          shot_cnt_q <= 6'h00;
          if (shot_stop_q) begin
            shot_state_q <= BTG_SHOT_IDLE;
            shot_on_q    <= 1'b0;
          end else begin
            shot_state_q <= BTG_SHOT_RUN;
            shot_on_q    <= 1'b1;
          end
        end
        BTG_SHOT_RUN: begin
          if (shot_stop_q || shot_cnt_q >= shot_last) begin
            shot_state_q <= BTG_SHOT_IDLE;
            shot_on_q    <= 1'b0;
          end else begin
            shot_cnt_q <= shot_cnt_q + 6'h01;
          end
        end
      endcase
    end
  end

endmodule

/* File: src/btg_pkg.sv */
// Shared constants of the buzzer tone generator
package btg_pkg;

  // I/O memory addresses of the four control nibbles
  localparam logic [15:0] BTG_ADDR_ENV_CTRL   = 16'hff6c; // buzzer_envelope_control
  localparam logic [15:0] BTG_ADDR_SHOT_CTRL  = 16'hff6d; // oneshot_control
  localparam logic [15:0] BTG_ADDR_TONE_SEL   = 16'hff6e; // tone_frequency_select
  localparam logic [15:0] BTG_ADDR_LEVEL_SEL  = 16'hff6f; // duty level select

  // Bit positions in buzzer_envelope_control
  localparam int BTG_BIT_BZ_EN        = 0;
  localparam int BTG_BIT_ENV_ON       = 1;
  localparam int BTG_BIT_ENV_RESTART  = 2;
  localparam int BTG_BIT_ENV_STEP     = 3;

  // Bit positions in oneshot_control
  localparam int BTG_BIT_PULSE_LEN    = 0;
  localparam int BTG_BIT_SHOT_TRIG    = 1;
  localparam int BTG_BIT_SHOT_STOP    = 2;

  // Values after reset
  localparam logic [3:0] BTG_RST_NIBBLE = 4'h0;
  localparam logic [2:0] BTG_RST_SEL    = 3'h0;

  // Tone period, in tone-counter ticks: base plus step per low code bit
  localparam logic [4:0] BTG_PERIOD_BASE = 5'h10; // 16 ticks
  localparam logic [4:0] BTG_PERIOD_STEP = 5'h04; // +4 ticks per code step
  // High-side count at level 1, per tone group
  localparam logic [4:0] BTG_DUTY_MAX_SHORT = 5'h08; // /16 and /20 group
  localparam logic [4:0] BTG_DUTY_MAX_LONG  = 5'h0c; // /24 and /28 group
  localparam logic [2:0] BTG_LEVEL_MIN      = 3'h7;  // level 8

  // Low-speed oscillator and the 256 Hz tick derived from it
  localparam int BTG_OSC_HZ        = 32768;
  localparam int BTG_TICK_HZ       = 256;
  localparam int BTG_PRE_DIV       = BTG_OSC_HZ / BTG_TICK_HZ;          // 128
  localparam logic [6:0] BTG_PRE_LAST = 7'(BTG_PRE_DIV - 1);

  // Times in microseconds and their length in 256 Hz ticks
  localparam int BTG_ENV_STEP_SHORT_US  = 62500;
  localparam int BTG_ENV_STEP_LONG_US   = 125000;
  localparam int BTG_SHOT_SHORT_US      = 31250;
  localparam int BTG_SHOT_LONG_US       = 125000;
  localparam logic [5:0] BTG_ENV_STEP_SHORT_TK =
    6'(BTG_ENV_STEP_SHORT_US * BTG_TICK_HZ / 1000000);                  // 16
  localparam logic [5:0] BTG_ENV_STEP_LONG_TK  =
    6'(BTG_ENV_STEP_LONG_US * BTG_TICK_HZ / 1000000);                   // 32
  localparam logic [5:0] BTG_SHOT_SHORT_TK     =
    6'(BTG_SHOT_SHORT_US * BTG_TICK_HZ / 1000000);                      // 8
  localparam logic [5:0] BTG_SHOT_LONG_TK      =
    6'(BTG_SHOT_LONG_US * BTG_TICK_HZ / 1000000);                       // 32

  // One-shot sequencer states
  typedef enum logic [1:0] {
    BTG_SHOT_IDLE,
    BTG_SHOT_WAIT,
    BTG_SHOT_RUN
  } btg_shot_e;

endpackage

/* File: src/btg_osc_sync.sv */
`timescale 1ns/1ps
// Brings the low-speed oscillator into the system clock domain and
// reports each accepted edge as a one-cycle pulse.
module btg_osc_sync (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic osc_in,
  output logic      rise_out,
  output logic      fall_out
);

  logic s1_q;   // First stage, read only by the second
  logic s2_q;   // Second stage
  logic s3_q;   // Third stage
  logic lvl_q;  // Accepted oscillator level

  // Three-stage synchroniser
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= osc_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once stages two and three agree on it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lvl_q    <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      rise_out <= 1'b0;
      fall_out <= 1'b0;
      if (s2_q == s3_q && s3_q != lvl_q) begin
        lvl_q    <= s3_q;
        rise_out <= s3_q;
        fall_out <= ~s3_q;
      end
    end
  end

endmodule

/* File: tb/btg_checker.sv */
`timescale 1ns/1ps
// Port-level checker; pin timing is counted in raw oscillator rises
module btg_checker
  import btg_pkg::*;
#(
  parameter bit POSITIVE_POL = 1'b1
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_IN,
  input  wire logic        LOW_SPEED_OSC_IN,
  input  wire logic [15:0] ADDR_IN,
  input  wire logic [3:0]  WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  input  wire logic [3:0]  RDATA_OUT,
  input  wire logic        BUZZER_OUT
);
  logic       osc_q;   // Last oscillator level
  logic       start_q; // A tone or shot was requested
  logic       en_q;    // Shadow of buzzer_enable
  logic       shot_q;  // A shot may still run
  logic [6:0] since_q; // Rises since last setup write
  logic [4:0] act_q;   // Rises in this active run
  logic [4:0] ina_q;   // Rises in this resting run
  logic       act;
  logic       rise;
  logic       wr_trig;
  logic       rd_shot;
  assign act     = BUZZER_OUT == POSITIVE_POL;
  assign rise    = LOW_SPEED_OSC_IN && !osc_q;
  assign wr_trig = WR_IN && ADDR_IN == BTG_ADDR_SHOT_CTRL && WDATA_IN[BTG_BIT_SHOT_TRIG];
  assign rd_shot = RD_IN && ADDR_IN == BTG_ADDR_SHOT_CTRL;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  // Register shadows; a busy read of zero proves the shot is over
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      start_q <= 1'b0;
      en_q    <= 1'b0;
      shot_q  <= 1'b0;
    end else begin
      if (WR_IN && ADDR_IN == BTG_ADDR_ENV_CTRL) begin
        en_q    <= WDATA_IN[BTG_BIT_BZ_EN];
        start_q <= start_q | WDATA_IN[BTG_BIT_BZ_EN];
      end
      if (wr_trig && !en_q) begin
        shot_q  <= 1'b1;
        start_q <= 1'b1;
      end else if ($past(rd_shot) && !RDATA_OUT[BTG_BIT_SHOT_TRIG]) begin
        shot_q <= 1'b0;
      end
    end
  end

  // Run lengths saturate so a stuck pin cannot wrap back into range
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      osc_q   <= 1'b0;
      since_q <= '0;
      act_q   <= '0;
      ina_q   <= '0;
    end else begin
      osc_q <= LOW_SPEED_OSC_IN;
      if (WR_IN && ADDR_IN != BTG_ADDR_SHOT_CTRL) since_q <= '0;
      else if (rise && since_q != 7'h7f) since_q <= since_q + 7'h01;
      if (!act) act_q <= '0;
      else if (rise && act_q != 5'h1f) act_q <= act_q + 5'h01;
      if (act) ina_q <= '0;
      else if (rise && ina_q != 5'h1f) ina_q <= ina_q + 5'h01;
    end
  end

  AST_REST: assert property (!start_q |-> BUZZER_OUT == !POSITIVE_POL)
    else $error("pin left rest level with no start");
  AST_ENRST0: assert property (RD_IN && ADDR_IN == BTG_ADDR_ENV_CTRL |=> !RDATA_OUT[2])
    else $error("envelope restart bit read as one");
  AST_STOP0: assert property ($past(rd_shot) |-> RDATA_OUT[3:2] == 2'b00)
    else $error("stop bit read as one");
  AST_LVL: assert property (RD_IN && ADDR_IN == BTG_ADDR_LEVEL_SEL |=> !RDATA_OUT[3])
    else $error("level register top bit read as one");
  AST_BUSY: assert property (wr_trig && !en_q ##2 rd_shot |=> RDATA_OUT[1])
    else $error("shot not busy after trigger");
  AST_NOTRIG: assert property (wr_trig && en_q && !shot_q ##2 rd_shot |=> !RDATA_OUT[1])
    else $error("shot started while tone enabled");
  AST_ACT: assert property (act |-> act_q <= 5'd13)
    else $error("active run too long");
  AST_TONE: assert property (en_q && since_q >= 7'd64 |-> ina_q <= 5'd24)
    else $error("tone missing while enabled");

  COV_SHOT: cover property (wr_trig && !en_q);
  COV_BUSY: cover property (rd_shot ##1 RDATA_OUT[1]);
  COV_TONE: cover property (en_q && since_q == 7'h7f);
endmodule

bind btg_top btg_checker #(.POSITIVE_POL(POSITIVE_POL)) chk (
  .CLK_SYS_IN      (CLK_SYS_IN),
  .RST_IN          (RST_IN),
  .LOW_SPEED_OSC_IN(LOW_SPEED_OSC_IN),
  .ADDR_IN         (ADDR_IN),
  .WDATA_IN        (WDATA_IN),
  .WR_IN           (WR_IN),
  .RD_IN           (RD_IN),
  .RDATA_OUT       (RDATA_OUT),
  .BUZZER_OUT      (BUZZER_OUT)
);

/* File: tb/btg_piezo.sv */
`timescale 1ns/1ps
// Piezo stand-in: times each active run and each drive period
module btg_piezo #(
  parameter bit POSITIVE_POL = 1'b1
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        pin_in,
  output logic      [15:0] hi_out,  // Last active run, sys cycles
  output logic      [15:0] per_out, // Active edge to active edge
  output logic      [7:0]  seq_out  // Bumps once per period
);
  logic        act;
  logic        act_q;
  logic [15:0] hi_q;
  logic [15:0] per_q;
  assign act = pin_in == POSITIVE_POL;
  // The element only reacts to drive edges, so time edge to edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_q   <= 1'b0;
      hi_q    <= '0;
      per_q   <= '0;
      hi_out  <= '0;
      per_out <= '0;
      seq_out <= '0;
    end else begin
      act_q <= act;
      per_q <= (act && !act_q) ? 16'h0001 : per_q + 16'h0001;
      if (act) hi_q <= act_q ? hi_q + 16'h0001 : 16'h0001;
      if (act && !act_q) begin
        per_out <= per_q;
        hi_out  <= hi_q;
        seq_out <= seq_out + 8'h01;
      end
    end
  end
endmodule

/* File: tb/btg_top_bench.sv */
`timescale 1ns/1ps
module btg_top_bench;
  import btg_pkg::*;
  logic        clk;
  logic        rst;
  logic        osc = 1'b0;
  logic [15:0] addr;
  logic [3:0]  wdata;
  logic        wr_en;
  logic        rd_en;
  logic [3:0]  rdata;
  logic        bz;
  logic [15:0] hi_w;
  logic [15:0] per_w;
  logic [7:0]  seq_w;
  logic [7:0]  note_q[$]; // Mask and expected nibble per read
  logic [7:0]  nt;
  logic [3:0]  last;      // Last nibble read
  logic [2:0]  lv;
  logic [1:0]  oc = 2'h0;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          seed = 12776;

  btg_top #(.POSITIVE_POL(1'b1)) uut (
    .CLK_SYS_IN(clk), .RST_IN(rst), .LOW_SPEED_OSC_IN(osc), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr_en), .RD_IN(rd_en), .RDATA_OUT(rdata), .BUZZER_OUT(bz));
  btg_piezo #(.POSITIVE_POL(1'b1)) pz (
    .clk_in(clk), .rst_in(rst), .pin_in(bz), .hi_out(hi_w), .per_out(per_w), .seq_out(seq_w));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Oscillator at one eighth of the clock; every time figure scales with it
  always @(posedge clk) begin
    cyc <= cyc + 1;
    oc  <= oc + 2'h1;
    if (oc == 2'h3) osc <= ~osc;
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, g);
    end
  endtask
  // Strobe for one edge, then let an idle edge pass before the next call
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  // A zero mask marks a poll whose value is used, not judged
  task automatic rd(input logic [15:0] a, input logic [3:0] m, input logic [3:0] e);
    note_q.push_back({m, e});
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    last = rdata;
  endtask
  // Read answers land one cycle after the strobe; oldest note first
  always @(posedge clk) begin
    if (rd_en === 1'b1) begin
      #1 nt = note_q.pop_front();
      if (nt[7:4] != 4'h0) chk("rdata", 16'(nt[3:0]), 16'(rdata & nt[7:4]));
    end
  end
  task automatic wait_meas(input int n);
    int k;
    logic [7:0] s;
    for (int i = 0; i < n; i++) begin
      s = seq_w;
      k = 0;
      while (seq_w === s && k < 2000) begin
        @(posedge clk);
        k++;
      end
      if (k >= 2000) begin
        miscompares++;
        tally_and_finish();
      end
    end
  endtask
  task automatic tone(input logic [2:0] c, input logic [2:0] l, input logic [3:0] ctl,
                      input logic [2:0] el);
    int u;
    wr(BTG_ADDR_TONE_SEL, {1'b0, c});
    wr(BTG_ADDR_LEVEL_SEL, {1'b0, l});
    wr(BTG_ADDR_ENV_CTRL, ctl);
    wait_meas(3);
    u = c[2] ? 8 : 4; // Whole or half oscillator cycles per count
    chk("period", 16'((16 + 4 * c[1:0]) * u), per_w);
    chk("active", 16'(((c[1] ? 12 : 8) - el) * u), hi_w);
  endtask
  // Busy time from first write; one tick is 1024 cycles here
  task automatic shot(input logic [3:0] w, input int gap, input logic [3:0] w2,
                      input int lo, input int hi);
    int t0;
    int k;
    t0 = cyc;
    wr(BTG_ADDR_SHOT_CTRL, w);
    if (gap > 0) begin
      repeat (gap) @(posedge clk);
      wr(BTG_ADDR_SHOT_CTRL, w2);
    end
    k = 0;
    do begin
      rd(BTG_ADDR_SHOT_CTRL, 4'h0, 4'h0);
      k++;
    end while (last[1] !== 1'b0 && k < 40000);
    if (k >= 40000) begin
      miscompares++;
      tally_and_finish();
    end
    chk_rng("busy", lo, hi, cyc - t0);
  endtask

  initial begin
    repeat (98000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1; addr = '0; wdata = '0; wr_en = 1'b0; rd_en = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) rd(16'hff6c + 16'(i), 4'hf, 4'h0);
    chk("rest", 16'h0, 16'(bz));
    wr(BTG_ADDR_TONE_SEL, 4'h5);
    rd(BTG_ADDR_TONE_SEL, 4'hf, 4'h5);
    wr(BTG_ADDR_LEVEL_SEL, 4'h6);
    rd(BTG_ADDR_LEVEL_SEL, 4'hf, 4'h6);
    wr(BTG_ADDR_ENV_CTRL, 4'ha);
    rd(BTG_ADDR_ENV_CTRL, 4'hf, 4'ha);
    wr(BTG_ADDR_SHOT_CTRL, 4'h1);
    rd(BTG_ADDR_SHOT_CTRL, 4'hf, 4'h1);
    wr(BTG_ADDR_ENV_CTRL, 4'h0);
    for (int c = 0; c < 8; c++) begin
      lv = 3'($random(seed));
      tone(3'(c), lv, 4'h1, lv);
    end
    wr(BTG_ADDR_ENV_CTRL, 4'h0);
    repeat (300) @(posedge clk);
    chk("rest", 16'h0, 16'(bz));
    tone(3'h0, 3'h7, 4'h3, 3'h0);
    repeat (17000) @(posedge clk);
    wait_meas(2);
    chk("active", 16'(7 * 4), hi_w);
    wr(BTG_ADDR_ENV_CTRL, 4'h7);
    wait_meas(3);
    chk("active", 16'(8 * 4), hi_w);
    rd(BTG_ADDR_ENV_CTRL, 4'hf, 4'h3);
    wr(BTG_ADDR_ENV_CTRL, 4'h0);
    repeat (300) @(posedge clk);
    wr(BTG_ADDR_ENV_CTRL, 4'h1);
    wr(BTG_ADDR_SHOT_CTRL, 4'h2);
    rd(BTG_ADDR_SHOT_CTRL, 4'hf, 4'h0);
    wr(BTG_ADDR_ENV_CTRL, 4'h2);
    wr(BTG_ADDR_LEVEL_SEL, 4'h2);
    repeat (300) @(posedge clk);
    shot(4'h2, 0, 4'h0, 8192, 9300);
    chk("active", 16'(6 * 4), hi_w);
    shot(4'h2, 4000, 4'h2, 12190, 13300);
    shot(4'h2, 200, 4'h4, 200, 2300);
    wr(BTG_ADDR_SHOT_CTRL, 4'h4);
    rd(BTG_ADDR_SHOT_CTRL, 4'hf, 4'h0);
    shot(4'h3, 0, 4'h0, 32768, 33900);
    tally_and_finish();
  end
endmodule
